// [common/vic_nest_defines.svh]
// Register offsets, field positions and reset values of the priority and nesting block
`ifndef VIC_NEST_DEFINES_SVH
`define VIC_NEST_DEFINES_SVH
`define VN_NUM_SRC 20
`define VN_ADDR_VECTOR_BASE 32'hFFFF0014
`define VN_ADDR_NORMAL_VECTOR 32'hFFFF001C
`define VN_ADDR_PRIO_A 32'hFFFF0020
`define VN_ADDR_PRIO_B 32'hFFFF0024
`define VN_ADDR_PRIO_C 32'hFFFF0028
`define VN_ADDR_NEST_CTRL 32'hFFFF0030
`define VN_ADDR_NORMAL_ISS 32'hFFFF003C
`define VN_ADDR_FAST_VECTOR 32'hFFFF011C
`define VN_ADDR_FAST_ISS 32'hFFFF013C
`define VN_RESET_WORD 32'h00000000
`define VN_PRIO_A_MASK 32'h07777070
`define VN_PRIO_B_MASK 32'h77777700
`define VN_PRIO_C_MASK 32'h00007777
`define VN_NEST_MASK 32'h00000003
`define VN_BASE_MASK 32'h0000FFFF
`define VN_ISS_MASK 32'h000000FF
`define VN_NORMAL_NEST_BIT 0
`define VN_FAST_NEST_BIT 1
`define VN_VEC_BASE_LSB 7
`define VN_VEC_SRC_LSB 2
`endif

// [common/vic_nest_pkg.sv]
// Types shared by the priority and nesting block
package vic_nest_pkg;
  typedef logic [2:0] prio_t;
  typedef logic [4:0] src_num_t;
  typedef logic [7:0] iss_t;
endpackage

// [rtl/vic_nest.sv]
// Priority, nesting and vector logic of the vectored interrupt controller
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`include "vic_nest_defines.svh"

// Contract
// - Second priority word: ext int 1 level in 26:24, ext int 0 in 22:20.
// - Second priority word: serial port level 14:12, converter level 10:8.
// - Second priority word: SPI master 18:16, I2C master 30:28, others reserved.
// - Third priority word: ext int 3 level 14:12, ext int 2 level 10:8.
// - Third priority word: SPI slave 6:4, I2C slave 2:0, 31:15 reserved.
// - Nesting control bit 0 enables normal nesting and priority levels.
// - Nesting control bit 1 enables fast nesting and priority levels.
// - Without nesting interrupts still delivered; fast beats normal always.
// - Normal vector read with nesting sets in-service bit at active priority.
// - Fast vector read with nesting sets fast in-service bit at priority.
// - Set in-service bit blocks that type at equal or lower priority.
// - Each in-service write clears only the lowest-index set bit.
// - Bits clear only after higher ones; in-service registers are 8 bits.
// - Fast vector: zeros 31:23 and 1:0, base 22:7, source 6:2.
// - Converter source encodes as 01000 in the source field.
// - All these registers reset to zero.
// - Normal vector mirrors fast vector layout for normal sources.
// - Vector base holds 16 bits in 15:0, upper bits read zero.
module vic_nest (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [19:0] normal_pend_i,
  input wire logic [19:0] fast_pend_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic normal_irq_o,
  output logic fast_irq_o
);

  // Register state
  logic [31:0] prio_a_ff, prio_b_ff, prio_c_ff, nest_ff, base_ff;
  logic [31:0] nxt_prio_a, nxt_prio_b, nxt_prio_c, nxt_nest, nxt_base;
  vic_nest_pkg::iss_t n_iss_ff, f_iss_ff, nxt_n_iss, nxt_f_iss;
  logic [31:0] dat_ff, nxt_dat;
  logic ack_ff, nxt_ack;
  logic n_irq_ff, f_irq_ff, nxt_n_irq, nxt_f_irq;

  // Priority level of one source number from the three priority words
  function automatic vic_nest_pkg::prio_t src_prio(input logic [4:0] s,
      input logic [31:0] pa, input logic [31:0] pb, input logic [31:0] pc);
    vic_nest_pkg::prio_t p;
    p = 3'h0;
    case (s)
      5'h01: p = pa[6:4];
      5'h02: p = pa[14:12];
      5'h03: p = pa[18:16];
      5'h04: p = pa[22:20];
      5'h05: p = pa[26:24];
      5'h08: p = pb[10:8];
      5'h09: p = pb[14:12];
      5'h0A: p = pb[18:16];
      5'h0B: p = pb[22:20];
      5'h0C: p = pb[26:24];
      5'h0D: p = pb[30:28];
      5'h0E: p = pc[2:0];
      5'h0F: p = pc[6:4];
      5'h10: p = pc[10:8];
      5'h11: p = pc[14:12];
      default: p = 3'h0;
    endcase
    return p;
  endfunction

  // Lowest set index of an in-service word, 8 when none
  function automatic logic [3:0] low_idx(input vic_nest_pkg::iss_t v);
    logic [3:0] r;
    r = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // Bit of the lowest set index, cleared by one write
  function automatic vic_nest_pkg::iss_t clear_low(input vic_nest_pkg::iss_t v);
    return v & (v - 8'h01);
  endfunction

  // Winner arbitration for each interrupt type
  logic [4:0] n_src, f_src;
  vic_nest_pkg::prio_t n_prio, f_prio;
  logic n_any, f_any;

  always_comb begin
    vic_nest_pkg::prio_t p;
    logic ok;
    p = 3'h0;
    ok = 1'b0;
    n_src = 5'h00;
    f_src = 5'h00;
    n_prio = 3'h0;
    f_prio = 3'h0;
    n_any = 1'b0;
    f_any = 1'b0;
    for (int s = 0; s < `VN_NUM_SRC; s++) begin
      p = src_prio(5'(s), prio_a_ff, prio_b_ff, prio_c_ff);
      // Blocked at or below any in-service level
      ok = !nest_ff[`VN_NORMAL_NEST_BIT] || ({1'b0, p} < low_idx(n_iss_ff));
      if (!nest_ff[`VN_NORMAL_NEST_BIT]) begin
        p = 3'h0;
      end
      // Strict compare keeps the lowest source on ties
      if (normal_pend_i[s] && ok && (!n_any || p < n_prio)) begin
        n_any = 1'b1;
        n_src = 5'(s);
        n_prio = p;
      end
      p = src_prio(5'(s), prio_a_ff, prio_b_ff, prio_c_ff);
      ok = !nest_ff[`VN_FAST_NEST_BIT] || ({1'b0, p} < low_idx(f_iss_ff));
      if (!nest_ff[`VN_FAST_NEST_BIT]) begin
        p = 3'h0;
      end
      if (fast_pend_i[s] && ok && (!f_any || p < f_prio)) begin
        f_any = 1'b1;
        f_src = 5'(s);
        f_prio = p;
      end
    end
  end

  // Vector words: base in 22:7, source in 6:2, all else zero
  logic [31:0] n_vec, f_vec;
  assign n_vec = {9'h000, base_ff[15:0], n_src, 2'h0};
  assign f_vec = {9'h000, base_ff[15:0], f_src, 2'h0};

  // Bus decode and register next values
  logic acc, wr, rd;
  logic [31:0] wmask;
  assign acc = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr = acc && wb_we_i;
  assign rd = acc && !wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_comb begin
    nxt_prio_a = prio_a_ff;
    nxt_prio_b = prio_b_ff;
    nxt_prio_c = prio_c_ff;
    nxt_nest = nest_ff;
    nxt_base = base_ff;
    nxt_n_iss = n_iss_ff;
    nxt_f_iss = f_iss_ff;
    nxt_dat = 32'h00000000;
    nxt_ack = acc;
    if (wr) begin
      case (wb_adr_i)
        `VN_ADDR_PRIO_A:
          nxt_prio_a = ((prio_a_ff & ~wmask) | (wb_dat_i & wmask)) & `VN_PRIO_A_MASK;
        `VN_ADDR_PRIO_B:
          nxt_prio_b = ((prio_b_ff & ~wmask) | (wb_dat_i & wmask)) & `VN_PRIO_B_MASK;
        `VN_ADDR_PRIO_C:
          nxt_prio_c = ((prio_c_ff & ~wmask) | (wb_dat_i & wmask)) & `VN_PRIO_C_MASK;
        `VN_ADDR_NEST_CTRL:
          nxt_nest = ((nest_ff & ~wmask) | (wb_dat_i & wmask)) & `VN_NEST_MASK;
        `VN_ADDR_VECTOR_BASE:
          nxt_base = ((base_ff & ~wmask) | (wb_dat_i & wmask)) & `VN_BASE_MASK;
        `VN_ADDR_NORMAL_ISS: nxt_n_iss = clear_low(n_iss_ff);
        `VN_ADDR_FAST_ISS: nxt_f_iss = clear_low(f_iss_ff);
        default: nxt_dat = 32'h00000000;
      endcase
    end
    if (rd) begin
      case (wb_adr_i)
        `VN_ADDR_PRIO_A: nxt_dat = prio_a_ff;
        `VN_ADDR_PRIO_B: nxt_dat = prio_b_ff;
        `VN_ADDR_PRIO_C: nxt_dat = prio_c_ff;
        `VN_ADDR_NEST_CTRL: nxt_dat = nest_ff;
        `VN_ADDR_VECTOR_BASE: nxt_dat = base_ff;
        `VN_ADDR_NORMAL_ISS: nxt_dat = {24'h000000, n_iss_ff};
        `VN_ADDR_FAST_ISS: nxt_dat = {24'h000000, f_iss_ff};
        `VN_ADDR_NORMAL_VECTOR: begin
          nxt_dat = n_vec;
          if (nest_ff[`VN_NORMAL_NEST_BIT] && n_any) begin
            nxt_n_iss = n_iss_ff | (8'h01 << n_prio);
          end
        end
        `VN_ADDR_FAST_VECTOR: begin
          nxt_dat = f_vec;
          if (nest_ff[`VN_FAST_NEST_BIT] && f_any) begin
            nxt_f_iss = f_iss_ff | (8'h01 << f_prio);
          end
        end
        default: nxt_dat = 32'h00000000;
      endcase
    end
    // Fast always wins over normal at the core
    nxt_f_irq = f_any;
    nxt_n_irq = n_any && !f_any;
  end

  // Register all state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prio_a_ff <= `VN_RESET_WORD;
      prio_b_ff <= `VN_RESET_WORD;
      prio_c_ff <= `VN_RESET_WORD;
      nest_ff <= `VN_RESET_WORD;
      base_ff <= `VN_RESET_WORD;
      n_iss_ff <= 8'h00;
      f_iss_ff <= 8'h00;
      dat_ff <= `VN_RESET_WORD;
      ack_ff <= 1'b0;
      n_irq_ff <= 1'b0;
      f_irq_ff <= 1'b0;
    end else begin
      prio_a_ff <= nxt_prio_a;
      prio_b_ff <= nxt_prio_b;
      prio_c_ff <= nxt_prio_c;
      nest_ff <= nxt_nest;
      base_ff <= nxt_base;
      n_iss_ff <= nxt_n_iss;
      f_iss_ff <= nxt_f_iss;
      dat_ff <= nxt_dat;
      ack_ff <= nxt_ack;
      n_irq_ff <= nxt_n_irq;
      f_irq_ff <= nxt_f_irq;
    end
  end

  assign wb_dat_o = dat_ff;
  assign wb_ack_o = ack_ff;
  assign normal_irq_o = n_irq_ff;
  assign fast_irq_o = f_irq_ff;

  // Checks on the registered behaviour
  AST_ISS_CLEAR_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == `VN_ADDR_NORMAL_ISS) |=> n_iss_ff == clear_low($past(n_iss_ff)))
    else $error("normal in-service write did not clear exactly one bit");
  AST_FISS_CLEAR_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == `VN_ADDR_FAST_ISS) |=> f_iss_ff == clear_low($past(f_iss_ff)))
    else $error("fast in-service write did not clear exactly one bit");
  AST_NVEC_SETS: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && wb_adr_i == `VN_ADDR_NORMAL_VECTOR && nest_ff[0] && n_any)
    |=> n_iss_ff[$past(n_prio)])
    else $error("normal vector read did not set in-service bit");
  AST_FVEC_SETS: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && wb_adr_i == `VN_ADDR_FAST_VECTOR && nest_ff[1] && f_any)
    |=> f_iss_ff[$past(f_prio)])
    else $error("fast vector read did not set in-service bit");
  AST_FAST_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
    fast_irq_o |-> !normal_irq_o)
    else $error("normal and fast both presented");
  AST_BLOCKED: assert property (@(posedge clk_i) disable iff (rst_i)
    (nest_ff[0] && n_any) |-> ({1'b0, n_prio} < low_idx(n_iss_ff)))
    else $error("normal winner at blocked level");
  AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !ack_ff) |=> ack_ff ##1 !ack_ff)
    else $error("bus ack not a single cycle");
  AST_VEC_LAYOUT: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_ff && $past(rd) && $past(wb_adr_i) == `VN_ADDR_FAST_VECTOR)
    |-> (wb_dat_o[31:23] == 9'h000 && wb_dat_o[1:0] == 2'h0
         && wb_dat_o[22:7] == base_ff[15:0]))
    else $error("fast vector layout wrong");
  AST_BASE_UPPER: assert property (@(posedge clk_i) disable iff (rst_i)
    base_ff[31:16] == 16'h0000)
    else $error("vector base upper bits nonzero");

  // Reset leaves outputs and registers at zero for the first cycle after it
  AST_RST_CLEAR: assert property (@(posedge clk_i)
    $fell(rst_i) |-> (wb_ack_o == 1'b0 && wb_dat_o == 32'h00000000
      && normal_irq_o == 1'b0 && fast_irq_o == 1'b0
      && prio_b_ff == 32'h00000000 && prio_c_ff == 32'h00000000
      && nest_ff == 32'h00000000 && base_ff == 32'h00000000
      && n_iss_ff == 8'h00 && f_iss_ff == 8'h00))
    else $error("state not cleared by reset");

  // Vector reads with nesting off leave the in-service words alone
  AST_NVEC_FLAT: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && wb_adr_i == `VN_ADDR_NORMAL_VECTOR && !nest_ff[`VN_NORMAL_NEST_BIT])
    |=> n_iss_ff == $past(n_iss_ff))
    else $error("normal vector read changed in-service word without nesting");
  AST_FVEC_FLAT: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && wb_adr_i == `VN_ADDR_FAST_VECTOR && !nest_ff[`VN_FAST_NEST_BIT])
    |=> f_iss_ff == $past(f_iss_ff))
    else $error("fast vector read changed in-service word without nesting");

  // In-service words change only through a bus access
  AST_NISS_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
    !acc |=> n_iss_ff == $past(n_iss_ff))
    else $error("normal in-service word changed without access");
  AST_FISS_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
    !acc |=> f_iss_ff == $past(f_iss_ff))
    else $error("fast in-service word changed without access");

  // Full-word writes land masked to the defined fields
  AST_PRIO_B_WR: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == `VN_ADDR_PRIO_B && wb_sel_i == 4'hF)
    |=> prio_b_ff == ($past(wb_dat_i) & `VN_PRIO_B_MASK))
    else $error("second priority word write wrong");
  AST_PRIO_C_WR: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == `VN_ADDR_PRIO_C && wb_sel_i == 4'hF)
    |=> prio_c_ff == ($past(wb_dat_i) & `VN_PRIO_C_MASK))
    else $error("third priority word write wrong");
  AST_NEST_WR: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == `VN_ADDR_NEST_CTRL && wb_sel_i == 4'hF)
    |=> nest_ff == ($past(wb_dat_i) & `VN_NEST_MASK))
    else $error("nesting control write wrong");
  AST_BASE_WR: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == `VN_ADDR_VECTOR_BASE && wb_sel_i == 4'hF)
    |=> base_ff == ($past(wb_dat_i) & `VN_BASE_MASK))
    else $error("vector base write wrong");

  // Register reads return the stored word with the ack
  AST_PRIO_B_RD: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && wb_adr_i == `VN_ADDR_PRIO_B)
    |=> (wb_ack_o && wb_dat_o == $past(prio_b_ff)))
    else $error("second priority word read wrong");
  AST_PRIO_C_RD: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && wb_adr_i == `VN_ADDR_PRIO_C)
    |=> (wb_ack_o && wb_dat_o == $past(prio_c_ff)))
    else $error("third priority word read wrong");
  AST_NISS_RD: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && wb_adr_i == `VN_ADDR_NORMAL_ISS)
    |=> (wb_ack_o && wb_dat_o == {24'h000000, $past(n_iss_ff)}))
    else $error("normal in-service read wrong");
  AST_FISS_RD: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && wb_adr_i == `VN_ADDR_FAST_ISS)
    |=> (wb_ack_o && wb_dat_o == {24'h000000, $past(f_iss_ff)}))
    else $error("fast in-service read wrong");

  // Vector reads carry the base and a legal source number
  AST_NVEC_LAYOUT: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && wb_adr_i == `VN_ADDR_NORMAL_VECTOR)
    |=> (wb_dat_o[31:23] == 9'h000 && wb_dat_o[1:0] == 2'h0
         && wb_dat_o[22:7] == $past(base_ff[15:0])))
    else $error("normal vector layout wrong");
  AST_FVEC_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && wb_adr_i == `VN_ADDR_FAST_VECTOR)
    |=> wb_dat_o[6:2] < 5'h14)
    else $error("fast vector source out of range");
  AST_NVEC_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && wb_adr_i == `VN_ADDR_NORMAL_VECTOR)
    |=> wb_dat_o[6:2] < 5'h14)
    else $error("normal vector source out of range");

  // The winner is pending and, without nesting, the lowest pending source
  AST_NWIN_PEND: assert property (@(posedge clk_i) disable iff (rst_i)
    n_any |-> normal_pend_i[n_src])
    else $error("normal winner not pending");
  AST_FWIN_PEND: assert property (@(posedge clk_i) disable iff (rst_i)
    f_any |-> fast_pend_i[f_src])
    else $error("fast winner not pending");
  AST_NFLAT_LOWEST: assert property (@(posedge clk_i) disable iff (rst_i)
    (!nest_ff[`VN_NORMAL_NEST_BIT] && n_any)
    |-> (normal_pend_i & ((20'h00001 << n_src) - 20'h00001)) == 20'h00000)
    else $error("normal flat winner not lowest source");
  AST_FFLAT_LOWEST: assert property (@(posedge clk_i) disable iff (rst_i)
    (!nest_ff[`VN_FAST_NEST_BIT] && f_any)
    |-> (fast_pend_i & ((20'h00001 << f_src) - 20'h00001)) == 20'h00000)
    else $error("fast flat winner not lowest source");
  AST_FBLOCKED: assert property (@(posedge clk_i) disable iff (rst_i)
    (nest_ff[1] && f_any) |-> ({1'b0, f_prio} < low_idx(f_iss_ff)))
    else $error("fast winner at blocked level");

  // Interrupt outputs follow the arbitration one cycle later
  AST_FIRQ_FOLLOW: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> fast_irq_o == $past(f_any))
    else $error("fast request output does not follow arbitration");
  AST_NIRQ_FOLLOW: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> normal_irq_o == $past(n_any && !f_any))
    else $error("normal request output does not follow arbitration");

endmodule

// [verif/core_model.sv]
// Core-side model: sources raising interrupts and a count of fast entries
`timescale 1ns/1ps
module core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [19:0] normal_req_i,
  input wire logic [19:0] fast_req_i,
  input wire logic fast_irq_i,
  output logic [19:0] normal_pend_o,
  output logic [19:0] fast_pend_o,
  output logic [7:0] fast_taken_o
);
  logic fast_seen_ff;
  // Pending lines launched on the clock; each fast entry counted once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      normal_pend_o <= 20'h00000;
      fast_pend_o <= 20'h00000;
      fast_seen_ff <= 1'b0;
      fast_taken_o <= 8'h00;
    end else begin
      normal_pend_o <= normal_req_i;
      fast_pend_o <= fast_req_i;
      fast_seen_ff <= fast_irq_i;
      if (fast_irq_i && !fast_seen_ff) begin
        fast_taken_o <= fast_taken_o + 8'h01;
      end
    end
  end
endmodule

// [verif/tb.sv]
// Self-checking bench for the priority and nesting block
`timescale 1ns/1ps
`include "vic_nest_defines.svh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [19:0] nreq = 20'h0;
  logic [19:0] freq = 20'h0;
  logic [19:0] npend;
  logic [19:0] fpend;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack;
  logic nirq;
  logic firq;
  logic [7:0] taken;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  localparam logic [31:0] ONES = 32'hFFFFFFFF;

  vic_nest DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .normal_pend_i(npend),
    .fast_pend_i(fpend), .wb_dat_o(rdat), .wb_ack_o(ack), .normal_irq_o(nirq),
    .fast_irq_o(firq));
  core_model partner (.clk_i(clk_i), .rst_i(rst_i), .normal_req_i(nreq), .fast_req_i(freq),
    .fast_irq_i(firq), .normal_pend_o(npend), .fast_pend_o(fpend), .fast_taken_o(taken));

  // Free-running clock
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // Expected vector word from base and source
  function automatic logic [31:0] vec(input logic [15:0] b, input logic [4:0] s);
    return {9'h000, b, s, 2'h0};
  endfunction

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One classic cycle, held until ack is seen high at a rising edge
  task automatic xfer(input logic [31:0] a, input logic [31:0] d, input logic w);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] ex, input string nm);
    xfer(a, 32'h0, 1'b0);
    `CHK(nm, ex, q)
  endtask

  // Let pending lines reach the outputs
  task automatic settle();
    repeat (4) @(posedge clk_i);
  endtask

  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      conclude();
    end
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(`VN_ADDR_PRIO_B, 32'h00000000, "prio_b_rst");
    rd_chk(`VN_ADDR_PRIO_C, 32'h00000000, "prio_c_rst");
    rd_chk(`VN_ADDR_NEST_CTRL, 32'h00000000, "nest_rst");
    rd_chk(`VN_ADDR_NORMAL_ISS, 32'h00000000, "niss_rst");
    rd_chk(`VN_ADDR_VECTOR_BASE, 32'h00000000, "base_rst");
    rd_chk(`VN_ADDR_FAST_ISS, 32'h00000000, "fiss_rst");
    xfer(`VN_ADDR_PRIO_B, ONES, 1'b1);
    rd_chk(`VN_ADDR_PRIO_B, 32'h77777700, "prio_b_mask");
    xfer(`VN_ADDR_PRIO_C, ONES, 1'b1);
    rd_chk(`VN_ADDR_PRIO_C, 32'h00007777, "prio_c_mask");
    xfer(`VN_ADDR_VECTOR_BASE, ONES, 1'b1);
    rd_chk(`VN_ADDR_VECTOR_BASE, 32'h0000FFFF, "base_mask");
    rd_chk(32'hFFFF0034, 32'h00000000, "unmapped");
    // Flat mode: converter level 7, serial 0, still lowest source wins
    xfer(`VN_ADDR_PRIO_B, 32'h00000700, 1'b1);
    nreq <= 20'h00300;
    settle();
    `CHK("nirq_flat", 1'b1, nirq)
    rd_chk(`VN_ADDR_NORMAL_VECTOR, vec(16'hFFFF, 5'h08), "nvec_flat");
    rd_chk(`VN_ADDR_NORMAL_ISS, 32'h00000000, "niss_flat");
    freq <= 20'h00008;
    settle();
    `CHK("firq_flat", 1'b1, firq)
    `CHK("nirq_under_fast", 1'b0, nirq)
    rd_chk(`VN_ADDR_FAST_ISS, 32'h00000000, "fiss_flat");
    freq <= 20'h00000;
    // Nesting on: converter 5, serial 2, ext2 and ext3 both 3
    xfer(`VN_ADDR_PRIO_B, 32'h00002500, 1'b1);
    xfer(`VN_ADDR_PRIO_C, 32'h00003300, 1'b1);
    xfer(`VN_ADDR_NEST_CTRL, 32'h00000003, 1'b1);
    rd_chk(`VN_ADDR_NEST_CTRL, 32'h00000003, "nest_set");
    rd_chk(`VN_ADDR_NORMAL_VECTOR, vec(16'hFFFF, 5'h09), "nvec_prio");
    rd_chk(`VN_ADDR_NORMAL_ISS, 32'h00000004, "niss_one");
    settle();
    `CHK("nirq_blocked", 1'b0, nirq)
    xfer(`VN_ADDR_PRIO_B, 32'h01002500, 1'b1);
    nreq <= 20'h01300;
    settle();
    `CHK("nirq_nested", 1'b1, nirq)
    rd_chk(`VN_ADDR_NORMAL_VECTOR, vec(16'hFFFF, 5'h0C), "nvec_nest");
    rd_chk(`VN_ADDR_NORMAL_ISS, 32'h00000006, "niss_two");
    xfer(`VN_ADDR_NORMAL_ISS, 32'h000000FF, 1'b1);
    rd_chk(`VN_ADDR_NORMAL_ISS, 32'h00000004, "niss_clr1");
    xfer(`VN_ADDR_NORMAL_ISS, 32'h000000FF, 1'b1);
    rd_chk(`VN_ADDR_NORMAL_ISS, 32'h00000000, "niss_clr2");
    nreq <= 20'h00000;
    freq <= 20'h30000;
    settle();
    `CHK("firq_nest", 1'b1, firq)
    rd_chk(`VN_ADDR_FAST_VECTOR, vec(16'hFFFF, 5'h10), "fvec_tie");
    rd_chk(`VN_ADDR_FAST_ISS, 32'h00000008, "fiss_one");
    settle();
    `CHK("firq_blocked", 1'b0, firq)
    xfer(`VN_ADDR_FAST_ISS, 32'h000000FF, 1'b1);
    rd_chk(`VN_ADDR_FAST_ISS, 32'h00000000, "fiss_clr");
    settle();
    `CHK("firq_again", 1'b1, firq)
    rd_chk(`VN_ADDR_FAST_VECTOR, vec(16'hFFFF, 5'h10), "fvec_again");
    rd_chk(`VN_ADDR_FAST_ISS, 32'h00000008, "fiss_again");
    `CHK("fast_taken", 8'h03, taken)
    conclude();
  end
endmodule
